//--- csp_pkg.sv
// Package with shared types, states and timing constants for the charger control.
package csp_pkg;

  // Clock rate in kHz (cycles per millisecond) and synchroniser stage count.
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned SYNC_STAGES = 2;

  // Documented times, in milliseconds.
  localparam int unsigned BOOST_RETRY_MS = 300;
  localparam int unsigned BOOST_ON_MS = 60;

  // Default times for values not given numerically, in milliseconds except the debounce in microseconds.
  // Top-off default stays below the 32-bit cycle counter range.
  localparam int unsigned TOPOFF_TIME_MS = 20000;
  localparam int unsigned PREQUAL_TIME_MS = 1800000;
  localparam int unsigned FASTCHARGE_TIME_MS = 36000000;
  localparam int unsigned OC_DEBOUNCE_US = 100;
  localparam int unsigned OC_RETRY_MS = 150;

  // Cycle counts derived from the times above.
  localparam int unsigned BOOST_RETRY_CYC = BOOST_RETRY_MS * CLK_KHZ;
  localparam int unsigned BOOST_ON_CYC = BOOST_ON_MS * CLK_KHZ;
  localparam int unsigned OC_DEBOUNCE_CYC = (OC_DEBOUNCE_US * CLK_KHZ) / 1000;
  localparam int unsigned OC_RETRY_CYC = OC_RETRY_MS * CLK_KHZ;

  // Current and voltage scaling.
  localparam logic [7:0] CUR_FULL = 8'h64;
  localparam logic [7:0] CUR_STEP = 8'h05;
  localparam logic [7:0] FOLD_ZERO_DEG = 8'h14;
  localparam logic [7:0] VREG_DROP_MV = 8'h96;

  // Charger states, one-hot.
  typedef enum logic [9:0] {
    ST_INIT     = 10'h001,
    ST_BUCK     = 10'h002,
    ST_PRECHG   = 10'h004,
    ST_TRICKLE  = 10'h008,
    ST_FC_CC    = 10'h010,
    ST_FC_CV    = 10'h020,
    ST_TOPOFF   = 10'h040,
    ST_DONE     = 10'h080,
    ST_TFAULT   = 10'h100,
    ST_TSHDN    = 10'h200
  } csp_state_t;

  // Battery temperature zone, from the thermistor comparators.
  typedef struct packed {
    logic cold;
    logic cool;
    logic warm;
    logic hot;
  } csp_zone_t;

  // Analog comparator results.
  typedef struct packed {
    logic input_valid;
    logic thm_above_en;
    logic vbat_above_prechg;
    logic vbat_above_trickle;
    logic vbat_above_reg;
    logic vbat_below_restart;
    logic ichg_below_topoff;
    logic tj_above_shdn;
    logic vsys_below_pu;
    logic ibat_above_oc;
    logic boost_overload;
    logic charger_input_below_boost;
    logic rd_detected;
    logic cc_active2;
  } csp_cmp_t;

  // Saturating timer compare, shared by the timer users.
  function automatic logic csp_expired(input logic [31:0] cnt,
                                       input logic [31:0] lim);
    return cnt >= lim;
  endfunction

endpackage

//--- csp_sync.sv
// Two-flop synchroniser for a bundle of comparator levels.
`timescale 1ns/10ps
module csp_sync (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire csp_pkg::csp_cmp_t d,
  input  wire csp_pkg::csp_zone_t zd,
  output csp_pkg::csp_cmp_t      q,
  output csp_pkg::csp_zone_t     zq
);

  csp_pkg::csp_cmp_t  s1_q;
  csp_pkg::csp_zone_t z1_q;

  // First stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      z1_q <= '0;
      q    <= '0;
      zq   <= '0;
    end else begin
      s1_q <= d;
      z1_q <= zd;
      q    <= s1_q;
      zq   <= z1_q;
    end
  end

endmodule

//--- csp_boost.sv
// Reverse boost control with overload retry and CC source handling.
`timescale 1ns/10ps
module csp_boost (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic charger_input_low,
  input  wire logic overload,
  input  wire logic rd_detected,
  input  wire logic cc_active2,
  output logic      boost_on,
  output logic      switch_closed,
  output logic      cc_lowpower,
  output logic      cc1_source,
  output logic      cc2_source
);

  logic [31:0] cnt_q;
  logic        off_q;
  logic        on_win_q;
  wire  logic  run = enable & charger_input_low;

  // Retry timing: 300 ms off after an overload, then a 60 ms trial window.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= '0;
      off_q    <= 1'b0;
      on_win_q <= 1'b0;
    end else if (!run) begin
      cnt_q    <= '0;
      off_q    <= 1'b0;
      on_win_q <= 1'b0;
    end else if (off_q) begin
      if (csp_pkg::csp_expired(cnt_q, 32'(csp_pkg::BOOST_RETRY_CYC - 1))) begin
        off_q    <= 1'b0;
        on_win_q <= 1'b1;
        cnt_q    <= '0;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end else if (overload && (!on_win_q ||
             csp_pkg::csp_expired(cnt_q, 32'(csp_pkg::BOOST_ON_CYC - 1)))) begin
      off_q <= 1'b1;
      cnt_q <= '0;
    end else if (on_win_q) begin
      cnt_q <= cnt_q + 32'h1;
      if (!overload) begin
        on_win_q <= 1'b0;
      end
    end
  end

  // Converter mode and CC pin drive.
  assign boost_on      = run;
  assign switch_closed = run & ~off_q;
  assign cc_lowpower   = run & ~rd_detected;
  assign cc1_source    = run & rd_detected & ~cc_active2;
  assign cc2_source    = run & rd_detected & cc_active2;

  // Overload outside the trial window opens the switch the next cycle.
  overload_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    run && !off_q && !on_win_q && overload |=> !switch_closed)
    else $error("switch stayed closed on overload");

  // Boost never runs with a live input.
  boost_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    boost_on |-> enable && charger_input_low)
    else $error("boost ran without enable or low input");

  // Only one CC source at a time.
  cc_single_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(cc1_source && cc2_source) && !(cc_lowpower && cc1_source))
    else $error("CC pins driven inconsistently");

  cov_retry: cover property (@(posedge clk) disable iff (!rst_n)
    off_q ##1 !off_q);

endmodule

//--- csp_ctrl.sv
`timescale 1ns/10ps
module csp_ctrl #(
  parameter int unsigned TOPOFF_CYC     = csp_pkg::TOPOFF_TIME_MS
                                          * csp_pkg::CLK_KHZ,
  parameter int unsigned PREQUAL_CYC    = 32'hffffffff,
  parameter int unsigned FASTCHARGE_CYC = 32'hffffffff,
  parameter int unsigned OC_RETRY_CYC   = csp_pkg::OC_RETRY_CYC,
  parameter int unsigned OC_DEBOUNCE_CYC = csp_pkg::OC_DEBOUNCE_CYC
) (
  input  wire logic               SYS_CLK,
  input  wire logic               RST_N,
  input  wire csp_pkg::csp_cmp_t  CMP,
  input  wire csp_pkg::csp_zone_t ZONE,
  input  wire logic               JEITA_FULL,
  input  wire logic               BOOST_ENABLE_INPUT,
  input  wire logic [7:0]         TJ_OVER_FOLD,
  output logic [7:0]              CHG_CUR_PCT,
  output logic                    VREG_REDUCE,
  output logic                    SOFT_START,
  output logic                    CHARGER_ON,
  output logic                    STAT_O,
  output logic                    STAT_OE_N,
  output logic                    INPUT_OK_N,
  output logic                    BATTERY_SWITCH_ON,
  output logic                    BUCK_ON,
  output logic                    SYSPU_LIMIT,
  output logic                    BOOST_ON,
  output logic                    BYP_SWITCH_ON,
  output logic                    CC_LOWPOWER,
  output logic                    CC1_SOURCE,
  output logic                    CC2_SOURCE,
  output csp_pkg::csp_state_t     STATE
);

  csp_pkg::csp_cmp_t   c;
  csp_pkg::csp_zone_t  z;
  csp_pkg::csp_state_t st_q;
  csp_pkg::csp_state_t st_d;
  logic [31:0]         tmr_q;
  logic [31:0]         oc_cnt_q;
  logic                oc_trip_q;
  logic                from_done_q;
  logic [7:0]          cur_q;

  // Comparator levels pass a two-flop synchroniser first.
  csp_sync u_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .d     (CMP),
    .zd    (ZONE),
    .q     (c),
    .zq    (z)
  );

  // Reverse boost path.
  csp_boost u_boost (
    .clk           (SYS_CLK),
    .rst_n         (RST_N),
    .enable        (BOOST_ENABLE_INPUT),
    .charger_input_low     (c.charger_input_below_boost),
    .overload      (c.boost_overload),
    .rd_detected   (c.rd_detected),
    .cc_active2    (c.cc_active2),
    .boost_on      (BOOST_ON),
    .switch_closed (BYP_SWITCH_ON),
    .cc_lowpower   (CC_LOWPOWER),
    .cc1_source    (CC1_SOURCE),
    .cc2_source    (CC2_SOURCE)
  );

  // Zone decode: suspend in hot/cold, adjust only in the full variant.
  wire logic zone_stop  = z.cold | z.hot;
  wire logic zone_half  = JEITA_FULL & z.cool & ~z.cold;
  wire logic zone_vdrop = JEITA_FULL & z.warm & ~z.hot;
  wire logic charging   = (st_q == csp_pkg::ST_PRECHG) ||
                          (st_q == csp_pkg::ST_TRICKLE) ||
                          (st_q == csp_pkg::ST_FC_CC) ||
                          (st_q == csp_pkg::ST_FC_CV) ||
                          (st_q == csp_pkg::ST_TOPOFF);
  wire logic pq_state   = (st_q == csp_pkg::ST_PRECHG) ||
                          (st_q == csp_pkg::ST_TRICKLE);
  wire logic fc_state   = (st_q == csp_pkg::ST_FC_CC) ||
                          (st_q == csp_pkg::ST_FC_CV);
  wire logic pq_exp  = csp_pkg::csp_expired(tmr_q, 32'(PREQUAL_CYC));
  wire logic fc_exp  = csp_pkg::csp_expired(tmr_q, 32'(FASTCHARGE_CYC));
  wire logic to_exp  = csp_pkg::csp_expired(tmr_q, 32'(TOPOFF_CYC));
  wire logic restart = c.vbat_below_restart;

  // Next-state logic; shutdown, then input loss, take priority over all else.
  always_comb begin
    st_d = st_q;
    if (c.tj_above_shdn) begin
      st_d = csp_pkg::ST_TSHDN;
    end else if (!c.input_valid) begin
      st_d = csp_pkg::ST_INIT;
    end else if (st_q == csp_pkg::ST_TFAULT) begin
      st_d = csp_pkg::ST_TFAULT;
    end else if (!c.thm_above_en) begin
      st_d = csp_pkg::ST_BUCK;
    end else begin
      case (st_q)
        csp_pkg::ST_INIT, csp_pkg::ST_BUCK, csp_pkg::ST_TSHDN: begin
          st_d = csp_pkg::ST_PRECHG;
        end
        csp_pkg::ST_PRECHG: begin
          if (pq_exp) st_d = csp_pkg::ST_TFAULT;
          else if (c.vbat_above_prechg) st_d = csp_pkg::ST_TRICKLE;
        end
        csp_pkg::ST_TRICKLE: begin
          if (pq_exp) st_d = csp_pkg::ST_TFAULT;
          else if (c.vbat_above_trickle) st_d = csp_pkg::ST_FC_CC;
        end
        csp_pkg::ST_FC_CC: begin
          if (fc_exp) st_d = csp_pkg::ST_TFAULT;
          else if (c.vbat_above_reg) st_d = csp_pkg::ST_FC_CV;
        end
        csp_pkg::ST_FC_CV: begin
          if (fc_exp) st_d = csp_pkg::ST_TFAULT;
          else if (c.ichg_below_topoff) st_d = csp_pkg::ST_TOPOFF;
        end
        csp_pkg::ST_TOPOFF: begin
          if (restart) st_d = csp_pkg::ST_FC_CC;
          else if (to_exp) st_d = csp_pkg::ST_DONE;
        end
        csp_pkg::ST_DONE: begin
          if (restart) st_d = csp_pkg::ST_FC_CC;
        end
        default: st_d = csp_pkg::ST_INIT;
      endcase
    end
  end

  // Timer restarts on a new timing class; CC and CV share one budget.
  wire logic same_class = (pq_state && ((st_d == csp_pkg::ST_PRECHG) ||
                           (st_d == csp_pkg::ST_TRICKLE))) ||
                          (fc_state && ((st_d == csp_pkg::ST_FC_CC) ||
                           (st_d == csp_pkg::ST_FC_CV))) ||
                          (st_d == st_q);
  wire logic tmr_clear  = !same_class || !charging;

  // State register and safety timer.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q        <= csp_pkg::ST_INIT;
      tmr_q       <= '0;
      from_done_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      tmr_q       <= tmr_clear ? 32'h0 : tmr_q + 32'h1;
      from_done_q <= (st_q == csp_pkg::ST_DONE) &&
                     (st_d == csp_pkg::ST_FC_CC);
    end
  end

  // Current target: foldback 5% per degree, zero at 20 degrees, halved cool.
  wire logic [7:0] fold_cut = (TJ_OVER_FOLD >= csp_pkg::FOLD_ZERO_DEG) ?
                              csp_pkg::CUR_FULL :
                              8'(TJ_OVER_FOLD * csp_pkg::CUR_STEP);
  wire logic [7:0] base_cur = zone_half ? (csp_pkg::CUR_FULL >> 1) :
                              csp_pkg::CUR_FULL;
  wire logic [7:0] fold_cur = (fold_cut >= base_cur) ? 8'h00 :
                              8'(base_cur - fold_cut);
  wire logic       chg_en   = charging && !zone_stop && c.thm_above_en;

  // Registered current command.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_q <= 8'h00;
    end else begin
      cur_q <= chg_en ? fold_cur : 8'h00;
    end
  end

  // Battery overcurrent: debounce, trip, then retry after low rail time.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      oc_cnt_q  <= '0;
      oc_trip_q <= 1'b0;
    end else if (!oc_trip_q) begin
      if (!c.ibat_above_oc) begin
        oc_cnt_q <= '0;
      end else if (csp_pkg::csp_expired(oc_cnt_q,
                                        32'(OC_DEBOUNCE_CYC - 1))) begin
        oc_trip_q <= 1'b1;
        oc_cnt_q  <= '0;
      end else begin
        oc_cnt_q <= oc_cnt_q + 32'h1;
      end
    end else if (!c.vsys_below_pu) begin
      oc_cnt_q <= '0;
    end else if (csp_pkg::csp_expired(oc_cnt_q, 32'(OC_RETRY_CYC - 1))) begin
      oc_trip_q <= 1'b0;
      oc_cnt_q  <= '0;
    end else begin
      oc_cnt_q <= oc_cnt_q + 32'h1;
    end
  end

  // Output assignments.
  assign CHG_CUR_PCT       = cur_q;
  assign VREG_REDUCE       = zone_vdrop;
  assign SOFT_START        = charging && !from_done_q;
  assign CHARGER_ON        = chg_en && !oc_trip_q;
  assign STAT_O            = 1'b0;
  assign STAT_OE_N         = !charging;
  assign INPUT_OK_N        = !c.input_valid;
  assign BATTERY_SWITCH_ON = !oc_trip_q;
  assign BUCK_ON           = c.input_valid && !oc_trip_q &&
                             (st_q != csp_pkg::ST_TSHDN) &&
                             (st_q != csp_pkg::ST_TFAULT);
  assign SYSPU_LIMIT       = c.vsys_below_pu;
  assign STATE             = st_q;

  // Done never commands current.
  done_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    st_q == csp_pkg::ST_DONE |=> cur_q == 8'h00)
    else $error("current commanded in done");

  // Timer fault is left only through init or thermal shutdown.
  tfault_exit_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    st_q == csp_pkg::ST_TFAULT |=> st_q inside {csp_pkg::ST_TFAULT,
      csp_pkg::ST_INIT, csp_pkg::ST_TSHDN})
    else $error("timer fault left without input cycle");

  // Timer fault floats status and stops charging.
  tfault_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    st_q == csp_pkg::ST_TFAULT |-> STAT_OE_N && !CHARGER_ON)
    else $error("timer fault output wrong");

  // Overtemperature reaches shutdown after the synchroniser delay.
  tshdn_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CMP.tj_above_shdn [*4] |-> st_q == csp_pkg::ST_TSHDN)
    else $error("shutdown not entered");

  // Input loss goes to init with timer cleared.
  init_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !c.input_valid && !c.tj_above_shdn |=> st_q == csp_pkg::ST_INIT
      ##1 tmr_q == 32'h0)
    else $error("init not entered on input loss");

  // Top-off expiry moves to done.
  topoff_done_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    st_d == csp_pkg::ST_TOPOFF && st_q == csp_pkg::ST_TOPOFF && to_exp
      |-> 1'b0)
    else $error("top-off held past its time");

  // Overcurrent trip opens the battery switch.
  oc_trip_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(oc_trip_q) |-> !BATTERY_SWITCH_ON && !BUCK_ON)
    else $error("switch closed after trip");

  // Thermistor low forces buck with no charge.
  thm_buck_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    c.input_valid && !c.thm_above_en && !c.tj_above_shdn &&
      st_q != csp_pkg::ST_TFAULT |=> !CHARGER_ON)
    else $error("charging with thermistor low");

  cov_done: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    st_q == csp_pkg::ST_DONE ##1 st_q == csp_pkg::ST_FC_CC);
  cov_tfault: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    st_q == csp_pkg::ST_TFAULT);
  cov_oc: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    $fell(oc_trip_q));

endmodule

//--- csp_env.sv
// Model of the adapter, battery and host controller driving the comparators.
`timescale 1ns/10ps
module csp_env (
  input  wire logic              adapter_on,
  input  wire logic [1:0]        bat_lvl,
  input  wire logic              mcu_thm_low,
  input  wire csp_pkg::csp_cmp_t misc,
  output csp_pkg::csp_cmp_t      cmp
);
  logic thm_pin;

  // The host output is open drain, so the bias pull-up sets the idle level.
  assign thm_pin = mcu_thm_low ? 1'b0 : 1'b1;

  // The battery level code keeps the voltage comparators in a legal order.
  always_comb begin
    cmp = misc;
    cmp.input_valid = adapter_on;
    cmp.charger_input_below_boost = ~adapter_on;
    cmp.thm_above_en = thm_pin;
    cmp.vbat_above_prechg = (bat_lvl >= 2'h1);
    cmp.vbat_above_trickle = (bat_lvl >= 2'h2);
    cmp.vbat_above_reg = (bat_lvl == 2'h3);
  end
endmodule

//--- testbench.sv
// Self-checking bench for the charger state and protection control.
`timescale 1ns/10ps
module testbench;
  localparam int unsigned TO_CYC = 20;
  logic                sys_clk, rst_n, adapter_on, thm_low;
  logic                jeita_full, boost_en;
  logic [1:0]          bat_lvl;
  logic [7:0]          tj_fold, cur_pct;
  logic                vreg_red, soft_start, chg_on, stat_o, stat_oe_n;
  logic                in_ok_n, bat_sw, buck_on, syspu, bst_on, byp_on;
  logic                cc_lp, cc1_src, cc2_src;
  csp_pkg::csp_cmp_t   misc, cmp;
  csp_pkg::csp_zone_t  zone;
  csp_pkg::csp_state_t state;
  int                  num_errors, checks_done;

  // Short counts keep the timed states reachable in a short run.
  csp_ctrl #(.TOPOFF_CYC(TO_CYC), .PREQUAL_CYC(100), .FASTCHARGE_CYC(500),
    .OC_RETRY_CYC(10), .OC_DEBOUNCE_CYC(4)) u_dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .CMP(cmp), .ZONE(zone),
    .JEITA_FULL(jeita_full), .BOOST_ENABLE_INPUT(boost_en),
    .TJ_OVER_FOLD(tj_fold), .CHG_CUR_PCT(cur_pct), .VREG_REDUCE(vreg_red),
    .SOFT_START(soft_start), .CHARGER_ON(chg_on), .STAT_O(stat_o),
    .STAT_OE_N(stat_oe_n), .INPUT_OK_N(in_ok_n), .BATTERY_SWITCH_ON(bat_sw),
    .BUCK_ON(buck_on), .SYSPU_LIMIT(syspu), .BOOST_ON(bst_on),
    .BYP_SWITCH_ON(byp_on), .CC_LOWPOWER(cc_lp), .CC1_SOURCE(cc1_src),
    .CC2_SOURCE(cc2_src), .STATE(state));

  csp_env u_env (.adapter_on(adapter_on), .bat_lvl(bat_lvl),
    .mcu_thm_low(thm_low), .misc(misc), .cmp(cmp));

  // Free-running 200 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s exp %b got %b", what, exp, got);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic chk_state(input csp_pkg::csp_state_t exp);
    checks_done++;
    if (state !== exp) begin
      num_errors++;
      $display("unexpected state exp %h got %h", exp, state);
    end
  endtask

  // Lets n rising edges pass, then samples at the falling edge.
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Bounded wait for a state; a miss ends the run.
  task automatic wait_state(input csp_pkg::csp_state_t exp, input int bound);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (state !== exp && n < bound) begin
      @(negedge sys_clk);
      n++;
    end
    chk_state(exp);
    if (state !== exp) test_done();
  endtask

  // Expected current: zone cut first, then 5 points per degree, 0 at 20.
  function automatic logic [7:0] exp_pct(input logic [7:0] deg,
      input csp_pkg::csp_zone_t z, input logic full);
    logic [7:0] base;
    if (z.cold || z.hot) return 8'h00;
    base = (z.cool && full) ? 8'h32 : 8'h64;
    if (deg >= 8'h14 || 8'h05 * deg >= base) return 8'h00;
    return base - 8'h05 * deg;
  endfunction

  // Main sequence.
  initial begin
    int n;
    int zsel;
    {rst_n, adapter_on, thm_low, jeita_full, boost_en} = 5'h00;
    {bat_lvl, tj_fold, misc, zone} = '0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(32'h8fc86a48));
    settle(7);
    chk_state(csp_pkg::ST_INIT);
    chk_bit("input_ok_n", 1'b1, in_ok_n);
    chk_byte("cur_pct", 8'h00, cur_pct);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    adapter_on <= 1'b1;
    bat_lvl <= 2'h2;
    wait_state(csp_pkg::ST_FC_CC, 40);
    chk_bit("input_ok_n", 1'b0, in_ok_n);
    chk_bit("stat_oe_n", 1'b0, stat_oe_n);
    // Random foldback and zone mix with the boundary degrees forced.
    for (int i = 0; i < 16; i++) begin
      zsel = (i < 5) ? i : int'($urandom % 5);
      @(posedge sys_clk);
      zone <= (zsel == 4) ? 4'h0 : 4'(4'h1 << zsel);
      jeita_full <= i[3] ^ i[0];
      tj_fold <= (i == 5) ? 8'h13 : (i == 6) ? 8'h14 : 8'($urandom % 24);
      if (zsel == 0 || zsel == 3) begin
        settle(8);
      end else begin
        wait_state(csp_pkg::ST_FC_CC, 60);
        settle(4);
        chk_bit("vreg_red", zone.warm & jeita_full, vreg_red);
      end
      chk_byte("cur_pct", exp_pct(tj_fold, zone, jeita_full), cur_pct);
    end
    @(posedge sys_clk);
    zone <= 4'h0;
    tj_fold <= 8'h00;
    misc.ibat_above_oc <= 1'b1;
    settle(3);
    chk_bit("bat_sw", 1'b1, bat_sw);
    n = 0;
    while (bat_sw !== 1'b0 && n < 12) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("bat_sw", 1'b0, bat_sw);
    chk_bit("buck_on", 1'b0, buck_on);
    if (bat_sw !== 1'b0) test_done();
    @(posedge sys_clk);
    misc.ibat_above_oc <= 1'b0;
    misc.vsys_below_pu <= 1'b1;
    settle(4);
    chk_bit("syspu", 1'b1, syspu);
    chk_bit("bat_sw", 1'b0, bat_sw);
    n = 0;
    while (bat_sw !== 1'b1 && n < 16) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("bat_sw", 1'b1, bat_sw);
    if (bat_sw !== 1'b1) test_done();
    @(posedge sys_clk);
    misc.vsys_below_pu <= 1'b0;
    // Back to fast charge first from top-off, then from done.
    for (int i = 0; i < 2; i++) begin
      wait_state(csp_pkg::ST_FC_CC, 40);
      @(posedge sys_clk);
      bat_lvl <= 2'h3;
      wait_state(csp_pkg::ST_FC_CV, 12);
      @(posedge sys_clk);
      misc.ichg_below_topoff <= 1'b1;
      wait_state(csp_pkg::ST_TOPOFF, 12);
      if (i == 1) begin
        settle(TO_CYC - 4);
        chk_state(csp_pkg::ST_TOPOFF);
        wait_state(csp_pkg::ST_DONE, 12);
        settle(3);
        chk_byte("cur_pct", 8'h00, cur_pct);
      end
      @(posedge sys_clk);
      misc.ichg_below_topoff <= 1'b0;
      misc.vbat_below_restart <= 1'b1;
      bat_lvl <= 2'h2;
      wait_state(csp_pkg::ST_FC_CC, 12);
      chk_bit("soft_start", ~i[0], soft_start);
      @(posedge sys_clk);
      misc.vbat_below_restart <= 1'b0;
    end
    wait_state(csp_pkg::ST_TFAULT, 700);
    chk_bit("chg_on", 1'b0, chg_on);
    chk_bit("stat_oe_n", 1'b1, stat_oe_n);
    chk_bit("stat_o", 1'b0, stat_o);
    @(posedge sys_clk);
    thm_low <= 1'b1;
    settle(8);
    chk_state(csp_pkg::ST_TFAULT);
    @(posedge sys_clk);
    thm_low <= 1'b0;
    adapter_on <= 1'b0;
    wait_state(csp_pkg::ST_INIT, 8);
    settle(2);
    chk_byte("cur_pct", 8'h00, cur_pct);
    chk_bit("input_ok_n", 1'b1, in_ok_n);
    @(posedge sys_clk);
    adapter_on <= 1'b1;
    wait_state(csp_pkg::ST_FC_CC, 20);
    @(posedge sys_clk);
    thm_low <= 1'b1;
    wait_state(csp_pkg::ST_BUCK, 8);
    chk_bit("chg_on", 1'b0, chg_on);
    @(posedge sys_clk);
    thm_low <= 1'b0;
    wait_state(csp_pkg::ST_FC_CC, 20);
    @(posedge sys_clk);
    misc.tj_above_shdn <= 1'b1;
    wait_state(csp_pkg::ST_TSHDN, 8);
    chk_bit("chg_on", 1'b0, chg_on);
    @(posedge sys_clk);
    misc.tj_above_shdn <= 1'b0;
    adapter_on <= 1'b0;
    boost_en <= 1'b1;
    settle(6);
    chk_bit("bst_on", 1'b1, bst_on);
    chk_bit("byp_on", 1'b1, byp_on);
    chk_bit("cc_lp", 1'b1, cc_lp);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      misc.rd_detected <= 1'b1;
      misc.cc_active2 <= k[0];
      settle(6);
      chk_bit("cc_lp", 1'b0, cc_lp);
      chk_bit("cc1_src", ~k[0], cc1_src);
      chk_bit("cc2_src", k[0], cc2_src);
    end
    @(posedge sys_clk);
    misc.boost_overload <= 1'b1;
    settle(6);
    chk_bit("byp_on", 1'b0, byp_on);
    @(posedge sys_clk);
    misc.boost_overload <= 1'b0;
    settle(20);
    chk_bit("byp_on", 1'b0, byp_on);
    @(posedge sys_clk);
    boost_en <= 1'b0;
    settle(4);
    chk_bit("bst_on", 1'b0, bst_on);
    @(posedge sys_clk);
    boost_en <= 1'b1;
    adapter_on <= 1'b1;
    settle(6);
    chk_bit("bst_on", 1'b0, bst_on);
    test_done();
  end
endmodule
